// *** design/sws_flag_readout.sv ***
// What this block does
// RULE1: source-current bit 0 leaves the input high impedance, 1 applies wetting current.
// RULE2: six-bit channel code 0 none, 1-14 ground, 15-22 supply, 23 temp, 24 battery.
// RULE3: channel select resets to the no-input code.
// RULE4: the chosen analog channel reads 0 in the next status word.
// RULE5: source-current at bit 6, channel at bits 5:0, other bits read zero.
// RULE6: switch status is read-only and returned during the following command.
// RULE7: status bit is 1 for a closed switch and 0 for open.
// RULE8: fault at 23, interrupt at 22, supply 21:14, ground 13:0; address 0x1f.
// RULE9: summary fault is the OR of all extended and wetting fault bits.
// RULE10: reset sets both the summary fault and interrupt flags.
// RULE11: reading switch status clears the interrupt flag.
// RULE12: summary fault holds until the fault register is read, which clears all.
// RULE13: both flags sit in bits 23:22 of every response but check and wetting config; the fault register response here reads bit 23 as 0.
// RULE14: a frame starts at chip select falling and carries 32 serial clocks.
// RULE15: the interrupt pin is released 1.0 ms after chip select falls.
// RULE16: a cleared fault whose condition persists is set again at once.
// RULE17: switch changes and newly set fault bits set the interrupt flag.
// RULE18: a response carrying the flag clears it; a held fault interrupts once.
// RULE19: the master reads faults by addressing the fault register then any command.
// RULE20: events latch into the interrupt flag in the cycle they are seen.
`timescale 1ns/1ns
`default_nettype none

module sws_flag_readout
    import sws_pkg::*;
#(
    parameter int FAULT_W = 8,
    parameter int INT_REL_CYC = INT_RELEASE_CYC
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic sclk,
    input wire logic cs_b,
    input wire logic mosi,
    output logic miso,
    output logic miso_oe,
    input wire logic [GND_N-1:0] ground_switch_input,
    input wire logic [SUP_N-1:0] supply_switch_input,
    input wire logic [FAULT_W-1:0] fault_cond,
    output logic int_b,
    output logic analog_output_mux_wetting_current,
    output logic [GND_N-1:0] analog_output_mux_ground_sel,
    output logic [SUP_N-1:0] analog_output_mux_supply_sel,
    output logic analog_output_mux_temp_sel,
    output logic analog_output_mux_batt_sel
);

    if (FAULT_W < 1 || FAULT_W > 21) begin : g_fault_w_bad
        $error("FAULT_W must be 1 to 21");
    end
    if (INT_REL_CYC < 2) begin : g_rel_cyc_bad
        $error("INT_REL_CYC must be at least 2");
    end

    localparam int SW_N = GND_N + SUP_N;

    logic [FRAME_BITS-1:0] tx_word;
    logic [FRAME_BITS-1:0] rx_word;
    logic rx_toggle;

    sws_link_shift u_shift (
        .sclk(sclk),
        .rst(rst),
        .cs_b(cs_b),
        .mosi(mosi),
        .tx_word(tx_word),
        .miso(miso),
        .miso_oe(miso_oe),
        .rx_word(rx_word),
        .rx_toggle(rx_toggle)
    );

    // the switch, fault and chip select pins and the link toggle pass two flip-flops before use
    logic [2:0] tog_sync;
    logic [1:0] cs_sync;
    logic cs_prev;
    logic [SW_N-1:0] sw_meta;
    logic [SW_N-1:0] sw_sync;
    logic [SW_N-1:0] sw_prev;
    logic [FAULT_W-1:0] flt_meta;
    logic [FAULT_W-1:0] flt_sync;
    logic [FAULT_W-1:0] flt_prev;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tog_sync <= 3'h0;
            cs_sync <= 2'h3;
            cs_prev <= 1'b1;
            sw_meta <= '0;
            sw_sync <= '0;
            sw_prev <= '0;
            flt_meta <= '0;
            flt_sync <= '0;
            flt_prev <= '0;
        end else begin
            tog_sync <= {tog_sync[1:0], rx_toggle};
            cs_sync <= {cs_sync[0], cs_b};
            cs_prev <= cs_sync[1];
            sw_meta <= {supply_switch_input, ground_switch_input};
            sw_sync <= sw_meta;
            sw_prev <= sw_sync;
            flt_meta <= fault_cond;
            flt_sync <= flt_meta;
            flt_prev <= flt_sync;
        end
    end

    logic cmd_take;
    logic cs_fall;
    logic [6:0] cmd_addr;
    logic cmd_write;
    logic [DATA_W-1:0] cmd_data;

    assign cmd_take = tog_sync[2] ^ tog_sync[1];
    assign cs_fall = cs_prev & ~cs_sync[1]; // [RULE14]
    assign cmd_addr = rx_word[ADDR_MSB -: ADDR_W];
    assign cmd_write = rx_word[RW_BIT];
    assign cmd_data = rx_word[DATA_W-1:0];

    // analog mux select register
    logic analog_output_mux_cur;
    logic [5:0] analog_output_mux_sel;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            analog_output_mux_cur <= ANALOG_OUTPUT_MUX_CUR_RST; // [RULE1]
            analog_output_mux_sel <= ANALOG_OUTPUT_MUX_SEL_RST; // [RULE3]
        end else if (cmd_take && cmd_write && cmd_addr == ADDR_ANALOG_OUTPUT_MUX) begin
            analog_output_mux_cur <= cmd_data[ANALOG_OUTPUT_MUX_CUR_BIT]; // [RULE5]
            analog_output_mux_sel <= cmd_data[ANALOG_OUTPUT_MUX_SEL_MSB:0];
        end
    end

    // codes above battery sense select nothing
    function automatic logic [SW_N+1:0] chan_onehot(input logic [5:0] code);
        logic [SW_N+1:0] hot;
        hot = '0;
        if (code >= CH_GND_FIRST && code <= CH_GND_LAST) begin
            hot[5'(code - CH_GND_FIRST)] = 1'b1;
        end else if (code >= CH_SUP_FIRST && code <= CH_SUP_LAST) begin
            hot[5'(code - CH_SUP_FIRST) + 5'(GND_N)] = 1'b1;
        end else if (code == CH_TEMP) begin
            hot[SW_N] = 1'b1;
        end else if (code == CH_BATT) begin
            hot[SW_N+1] = 1'b1;
        end
        return hot;
    endfunction

    logic [SW_N+1:0] sel_hot;
    logic [SW_N+1:0] analog_output_mux_hot;

    assign sel_hot = chan_onehot(analog_output_mux_sel);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            analog_output_mux_hot <= '0;
            analog_output_mux_wetting_current <= ANALOG_OUTPUT_MUX_CUR_RST;
        end else begin
            analog_output_mux_hot <= sel_hot; // [RULE2]
            analog_output_mux_wetting_current <= analog_output_mux_cur; // [RULE1]
        end
    end

    assign analog_output_mux_ground_sel = analog_output_mux_hot[GND_N-1:0];
    assign analog_output_mux_supply_sel = analog_output_mux_hot[SW_N-1:GND_N];
    assign analog_output_mux_temp_sel = analog_output_mux_hot[SW_N];
    assign analog_output_mux_batt_sel = analog_output_mux_hot[SW_N+1];

    // fault flags: latched until the fault register is read
    logic [FAULT_W-1:0] fault_flag;
    logic por_flag;
    logic fault_summary;
    logic fault_read;

    assign fault_read = cmd_take && cmd_addr == ADDR_FAULT;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fault_flag <= '0;
            por_flag <= POR_FLAG_RST; // [RULE10]
        end else begin
            if (fault_read) begin
                por_flag <= 1'b0; // [RULE12]
            end
            // the live condition wins over the read, so a held fault comes straight back
            fault_flag <= (fault_read ? '0 : fault_flag) | flt_sync; // [RULE16]
        end
    end

    assign fault_summary = (|fault_flag) | por_flag; // [RULE9]

    // interrupt events: switch edges and fault rises only
    logic sw_event;
    logic flt_event;
    logic int_event;
    logic flag_carried;
    logic intflg;

    assign sw_event = |(sw_sync ^ sw_prev); // [RULE17]
    // a fault still standing gives no new edge, hence no repeat interrupt
    assign flt_event = |(flt_sync & ~flt_prev); // [RULE18]
    assign int_event = sw_event | flt_event;
    assign flag_carried = cmd_take && cmd_addr != ADDR_LINK_CHECK && cmd_addr != ADDR_WET_CFG;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            intflg <= INTFLG_RST; // [RULE10]
        end else if (int_event) begin
            intflg <= 1'b1; // [RULE20]
        end else if (flag_carried) begin
            intflg <= 1'b0; // [RULE11] [RULE18]
        end
    end

    // response word for the command just taken, shifted out in the next frame
    logic [DATA_W-1:0] status_bits;
    logic [FRAME_BITS-1:0] next_tx_word;

    always_comb begin
        status_bits = '0;
        status_bits[BIT_FAULT] = fault_summary; // [RULE8]
        status_bits[BIT_INT] = intflg;
        status_bits[SUP_LSB +: SUP_N] = sw_sync[SW_N-1:GND_N]; // [RULE7]
        status_bits[GND_LSB +: GND_N] = sw_sync[GND_N-1:0];
        status_bits[SW_N-1:0] = status_bits[SW_N-1:0] & ~sel_hot[SW_N-1:0]; // [RULE4]
    end

    always_comb begin
        next_tx_word = '0;
        next_tx_word[ADDR_MSB -: ADDR_W] = cmd_addr;
        next_tx_word[RW_BIT] = cmd_write;
        next_tx_word[BIT_FAULT] = fault_summary; // [RULE13]
        next_tx_word[BIT_INT] = intflg;
        case (cmd_addr)
            ADDR_STATUS: begin
                next_tx_word[DATA_W-1:0] = status_bits; // [RULE6]
            end
            ADDR_ANALOG_OUTPUT_MUX: begin
                next_tx_word[ANALOG_OUTPUT_MUX_CUR_BIT] = analog_output_mux_cur; // [RULE5]
                next_tx_word[ANALOG_OUTPUT_MUX_SEL_MSB:0] = analog_output_mux_sel;
            end
            ADDR_FAULT: begin
                next_tx_word[BIT_FAULT] = 1'b0;
                next_tx_word[0] = por_flag;
                next_tx_word[FAULT_W:1] = fault_flag;
            end
            ADDR_LINK_CHECK, ADDR_WET_CFG: begin
                next_tx_word[BIT_FAULT] = 1'b0; // [RULE13]
                next_tx_word[BIT_INT] = 1'b0;
            end
            default: begin
                next_tx_word[DATA_W-1:0] = next_tx_word[DATA_W-1:0];
            end
        endcase
    end

    // held between frames so the link side may read it without a second crossing
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tx_word <= '0;
        end else if (cmd_take) begin
            tx_word <= next_tx_word; // [RULE6] [RULE19]
        end
    end

    // interrupt pin, released a fixed time after chip select falls
    sws_rel_state_t rel_state;
    logic [31:0] rel_cnt;
    logic rel_done;
    logic int_active;

    assign rel_done = rel_state == SWS_REL_WAIT && rel_cnt == 32'h1;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rel_state <= SWS_REL_IDLE;
            rel_cnt <= 32'h0;
        end else begin
            case (rel_state)
                SWS_REL_IDLE: begin
                    if (cs_fall) begin
                        rel_state <= SWS_REL_WAIT;
                        rel_cnt <= 32'(INT_REL_CYC);
                    end
                end
                SWS_REL_WAIT: begin
                    if (cs_fall) begin
                        rel_cnt <= 32'(INT_REL_CYC);
                    end else if (rel_cnt == 32'h1) begin
                        rel_state <= SWS_REL_IDLE; // [RULE15]
                        rel_cnt <= 32'h0;
                    end else begin
                        rel_cnt <= rel_cnt - 32'h1;
                    end
                end
                default: begin
                    rel_state <= SWS_REL_IDLE;
                    rel_cnt <= 32'h0;
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            int_active <= 1'b1; // [RULE10]
        end else if (int_event) begin
            int_active <= 1'b1; // [RULE17]
        end else if (rel_done) begin
            int_active <= 1'b0; // [RULE15]
        end
    end

    assign int_b = ~int_active;

    default clocking dflt_cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence fault_read_s;
        cmd_take && cmd_addr == ADDR_FAULT;
    endsequence

    sequence status_read_s;
        cmd_take && cmd_addr == ADDR_STATUS;
    endsequence

    sequence quiet_s;
        !int_event;
    endsequence

    por_flags_a: assert property ($past(rst) |-> intflg && fault_summary && !int_b) // [RULE10]
        else $error("flags not set after reset");

    analog_output_mux_default_a: assert property ($past(rst) |-> analog_output_mux_sel == CH_NONE) // [RULE3]
        else $error("channel select not at no-input after reset");

    status_clear_a: assert property (status_read_s ##0 quiet_s ##1 quiet_s |-> !intflg) // [RULE11]
        else $error("status read left interrupt flag set");

    fault_hold_a: assert property (fault_summary && !fault_read |=> fault_summary) // [RULE12]
        else $error("summary fault dropped without fault read");

    fault_clear_a: assert property (fault_read_s ##0 (flt_sync == '0) |=> !fault_summary) // [RULE12]
        else $error("fault read did not clear summary");

    fault_refire_a: assert property (flt_sync != '0
        |=> (fault_flag & $past(flt_sync)) == $past(flt_sync) && fault_summary) // [RULE16]
        else $error("standing fault not latched");

    switch_event_a: assert property (sw_sync != sw_prev |=> intflg) // [RULE20]
        else $error("switch change not latched");

    held_fault_a: assert property (flt_sync == flt_prev && !sw_event && flag_carried |=> !intflg) // [RULE18]
        else $error("held fault raised interrupt again");

    resp_flags_a: assert property (cmd_take && cmd_addr == ADDR_ANALOG_OUTPUT_MUX
        |=> tx_word[BIT_FAULT:BIT_INT] == {$past(fault_summary), $past(intflg)}) // [RULE13]
        else $error("response flags wrong");

    check_noflags_a: assert property (cmd_take && cmd_addr == ADDR_LINK_CHECK
        |=> tx_word[BIT_FAULT:BIT_INT] == 2'b00) // [RULE13]
        else $error("check response carried flags");

    analog_output_mux_mask_a: assert property (status_read_s ##0 analog_output_mux_sel == CH_GND_FIRST |=> !tx_word[0]) // [RULE4]
        else $error("selected channel not masked");

    analog_output_mux_decode_a: assert property (analog_output_mux_sel == CH_BATT |=> analog_output_mux_batt_sel && !analog_output_mux_temp_sel
        && analog_output_mux_ground_sel == '0) // [RULE2]
        else $error("battery channel decode wrong");

    release_load_a: assert property (cs_fall |=> rel_cnt == 32'(INT_REL_CYC)) // [RULE15]
        else $error("release timer not loaded on chip select fall");

    release_pin_a: assert property (rel_done && !int_event
        |=> int_b ##1 (int_b || $past(int_event))) // [RULE15]
        else $error("interrupt pin not released");

endmodule

`default_nettype wire

// *** common/sws_pkg.sv ***
package sws_pkg;

    localparam int FRAME_BITS = 32;
    localparam int ADDR_W = 7;
    localparam int DATA_W = 24;
    localparam int ADDR_MSB = 31;
    localparam int RW_BIT = 24;

    localparam logic [6:0] ADDR_ANALOG_OUTPUT_MUX = 7'h1d;
    localparam logic [6:0] ADDR_STATUS = 7'h1f;
    localparam logic [6:0] ADDR_FAULT = 7'h21;
    localparam logic [6:0] ADDR_LINK_CHECK = 7'h01;
    localparam logic [6:0] ADDR_WET_CFG = 7'h02;

    localparam int BIT_FAULT = 23;
    localparam int BIT_INT = 22;
    localparam int SUP_LSB = 14;
    localparam int GND_LSB = 0;
    localparam int ANALOG_OUTPUT_MUX_CUR_BIT = 6;
    localparam int ANALOG_OUTPUT_MUX_SEL_MSB = 5;

    localparam int GND_N = 14;
    localparam int SUP_N = 8;

    localparam logic [5:0] CH_NONE = 6'h00;
    localparam logic [5:0] CH_GND_FIRST = 6'h01;
    localparam logic [5:0] CH_GND_LAST = 6'h0e;
    localparam logic [5:0] CH_SUP_FIRST = 6'h0f;
    localparam logic [5:0] CH_SUP_LAST = 6'h16;
    localparam logic [5:0] CH_TEMP = 6'h17;
    localparam logic [5:0] CH_BATT = 6'h18;

    localparam logic [5:0] ANALOG_OUTPUT_MUX_SEL_RST = CH_NONE;
    localparam logic ANALOG_OUTPUT_MUX_CUR_RST = 1'b0;
    localparam logic INTFLG_RST = 1'b1;
    localparam logic POR_FLAG_RST = 1'b1;

    localparam real INT_RELEASE_MS = 1.0;
    localparam real CLK_MHZ = 100.0;
    localparam int INT_RELEASE_CYC = int'($floor(INT_RELEASE_MS * 1000.0 * CLK_MHZ));

    typedef enum {
        SWS_REL_IDLE,
        SWS_REL_WAIT
    } sws_rel_state_t;

endpackage

// *** design/sws_link_shift.sv ***
`timescale 1ns/1ns
`default_nettype none

module sws_link_shift
    import sws_pkg::*;
(
    input wire logic sclk,
    input wire logic rst,
    input wire logic cs_b,
    input wire logic mosi,
    input wire logic [FRAME_BITS-1:0] tx_word,
    output logic miso,
    output logic miso_oe,
    output logic [FRAME_BITS-1:0] rx_word,
    output logic rx_toggle
);

    logic frame_idle;
    logic [5:0] bit_cnt;
    logic [FRAME_BITS-1:0] shift_in;
    logic [4:0] out_idx;

    // chip select high holds the bit engine reset, since sclk stops between frames
    assign frame_idle = cs_b | rst;

    always_ff @(posedge sclk or posedge frame_idle) begin
        if (frame_idle) begin
            bit_cnt <= 6'h00;
            shift_in <= '0;
        end else begin
            bit_cnt <= bit_cnt + 6'h01;
            shift_in <= {shift_in[FRAME_BITS-2:0], mosi};
        end
    end

    // the word is published with a toggle; it stays put until the next frame ends
    always_ff @(posedge sclk or posedge rst) begin
        if (rst) begin
            rx_word <= '0;
            rx_toggle <= 1'b0;
        end else if (!cs_b && bit_cnt == 6'(FRAME_BITS - 1)) begin // [RULE14]
            rx_word <= {shift_in[FRAME_BITS-2:0], mosi};
            rx_toggle <= ~rx_toggle;
        end
    end

    // msb goes out first and moves on each falling edge
    always_ff @(negedge sclk or posedge frame_idle) begin
        if (frame_idle) begin
            out_idx <= 5'h1f;
        end else begin
            out_idx <= 5'h1f - bit_cnt[4:0]; // [RULE14]
        end
    end

    // tx_word is held steady by the other domain for the whole frame
    assign miso = tx_word[out_idx];
    assign miso_oe = ~cs_b;

endmodule

`default_nettype wire

// *** verif/sws_spi_master_model.sv ***
`timescale 1ns/1ns
`default_nettype none

module sws_spi_master_model (
    output logic sclk,
    output logic cs_b,
    output logic mosi,
    input wire logic miso
);
    initial begin
        sclk = 1'b0;
        cs_b = 1'b1;
        mosi = 1'b0;
    end

    // one mode-0 frame of 32 clocks at 15 ns; sclk rests low outside frames
    task automatic xfer(input logic [31:0] cmd, output logic [31:0] resp);
        #3;
        cs_b = 1'b0;
        for (int i = 31; i >= 0; i--) begin
            mosi = cmd[i];
            #7;
            sclk = 1'b1;
            resp[i] = miso;
            #8;
            sclk = 1'b0;
        end
        #8;
        cs_b = 1'b1;
        // deselected line must not keep looking like the last bit
        mosi = ~mosi;
        // gap well above the 3 clk the response needs to settle
        #200;
    endtask
endmodule

`default_nettype wire

// *** verif/switch_status_flag_readout_tb_top.sv ***
`timescale 1ns/1ns
`default_nettype none

module switch_status_flag_readout_tb_top
    import sws_pkg::*;
;
    localparam int REL = 200;
    localparam logic [31:0] ALL = 32'hffffffff;
    logic clk, rst, sclk, cs_b, mosi, miso, miso_oe, int_b, wet, temp_sel, batt_sel;
    logic [GND_N-1:0] gnd, gsel;
    logic [SUP_N-1:0] sup, ssel;
    logic [7:0] flt;
    logic [31:0] r, am;
    int bad_count, cmp_count;
    int cyc = 0;

    assign am = {7'h00, wet, gsel, ssel, temp_sel, batt_sel};

    sws_flag_readout #(.FAULT_W(8), .INT_REL_CYC(REL)) uut (
        .clk(clk), .rst(rst), .sclk(sclk), .cs_b(cs_b), .mosi(mosi),
        .miso(miso), .miso_oe(miso_oe),
        .ground_switch_input(gnd), .supply_switch_input(sup), .fault_cond(flt),
        .int_b(int_b), .analog_output_mux_wetting_current(wet), .analog_output_mux_ground_sel(gsel),
        .analog_output_mux_supply_sel(ssel), .analog_output_mux_temp_sel(temp_sel), .analog_output_mux_batt_sel(batt_sel)
    );

    sws_spi_master_model m (.sclk(sclk), .cs_b(cs_b), .mosi(mosi), .miso(miso));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic test_done;
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            bad_count++;
            $display("ERROR t=%0t run did not finish", $time);
            test_done();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] mask);
        cmp_count++;
        if ((got & mask) !== (exp & mask)) begin
            bad_count++;
            $display("ERROR t=%0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic xf(input logic [6:0] a, input logic w, input logic [23:0] d,
                      output logic [31:0] resp);
        @(negedge clk);
        m.xfer({a, w, d}, resp);
    endtask

    function automatic logic [31:0] st(input logic f, input logic i);
        return {ADDR_STATUS, 1'b0, f, i, sup, gnd};
    endfunction

    function automatic logic [31:0] am_exp(input int c);
        logic [13:0] g;
        logic [7:0] s;
        g = '0;
        s = '0;
        if (c >= 1 && c <= 14) g[c-1] = 1'b1;
        if (c >= 15 && c <= 22) s[c-15] = 1'b1;
        return {7'h00, c[0], g, s, c == 23, c == 24};
    endfunction

    initial begin
        rst = 1'b1;
        gnd = 14'h2a5a;
        sup = 8'hc3;
        flt = 8'h00;
        bad_count = 0;
        cmp_count = 0;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        chk({31'h0, int_b}, 32'h0, ALL);
        chk(am, 32'h0, ALL);
        xf(ADDR_LINK_CHECK, 1'b0, 24'h0, r);
        xf(ADDR_WET_CFG, 1'b0, 24'h0, r);
        chk(r, 32'h0, 32'h00c00000);
        xf(ADDR_STATUS, 1'b0, 24'h0, r);
        chk(r, 32'h0, 32'h00c00000);
        xf(ADDR_STATUS, 1'b0, 24'h0, r);
        chk(r, st(1'b1, 1'b1), ALL);
        chk({31'h0, miso_oe}, 32'h0, ALL);
        $display("test reset flags done");

        xf(ADDR_FAULT, 1'b0, 24'h0, r);
        chk(r, st(1'b1, 1'b0), ALL);
        xf(ADDR_STATUS, 1'b0, 24'h0, r);
        chk(r, {ADDR_FAULT, 1'b0, 24'h000001}, ALL);
        xf(ADDR_STATUS, 1'b0, 24'h0, r);
        chk(r, st(1'b0, 1'b0), ALL);
        $display("test flag clearing done");

        repeat (250) @(negedge clk);
        chk({31'h0, int_b}, 32'h1, ALL);
        gnd = gnd ^ 14'h0008;
        repeat (6) @(negedge clk);
        chk({31'h0, int_b}, 32'h0, ALL);
        xf(ADDR_STATUS, 1'b0, 24'h0, r);
        chk({31'h0, int_b}, 32'h0, ALL);
        repeat (140) @(negedge clk);
        chk({31'h0, int_b}, 32'h1, ALL);
        xf(ADDR_STATUS, 1'b0, 24'h0, r);
        chk(r, st(1'b0, 1'b1), ALL);
        xf(ADDR_STATUS, 1'b0, 24'h0, r);
        chk(r, st(1'b0, 1'b0), ALL);
        $display("test switch interrupt done");

        flt = 8'h04;
        repeat (6) @(negedge clk);
        xf(ADDR_STATUS, 1'b0, 24'h0, r);
        xf(ADDR_STATUS, 1'b0, 24'h0, r);
        chk(r, st(1'b1, 1'b1), ALL);
        xf(ADDR_FAULT, 1'b0, 24'h0, r);
        xf(ADDR_STATUS, 1'b0, 24'h0, r);
        chk(r, 32'h00000008, 32'h003fffff);
        xf(ADDR_STATUS, 1'b0, 24'h0, r);
        chk(r, st(1'b1, 1'b0), ALL);
        flt = 8'h00;
        repeat (6) @(negedge clk);
        xf(ADDR_FAULT, 1'b0, 24'h0, r);
        xf(ADDR_STATUS, 1'b0, 24'h0, r);
        xf(ADDR_STATUS, 1'b0, 24'h0, r);
        chk(r, st(1'b0, 1'b0), ALL);
        $display("test fault flags done");

        // unused data bits are written as ones and must read back as zero
        for (int c = 0; c <= 25; c++) begin
            xf(ADDR_ANALOG_OUTPUT_MUX, 1'b1, {16'hffff, 1'b1, c[0], c[5:0]}, r);
            chk(am, am_exp(c), ALL);
        end
        xf(ADDR_ANALOG_OUTPUT_MUX, 1'b0, 24'h0, r);
        xf(ADDR_STATUS, 1'b0, 24'h0, r);
        chk(r, {ADDR_ANALOG_OUTPUT_MUX, 1'b0, 24'h000059}, ALL);
        $display("test analog select done");

        xf(ADDR_ANALOG_OUTPUT_MUX, 1'b1, 24'h000001, r);
        gnd = gnd | 14'h0001;
        repeat (6) @(negedge clk);
        xf(ADDR_STATUS, 1'b0, 24'h0, r);
        xf(ADDR_STATUS, 1'b0, 24'h0, r);
        chk(r, st(1'b0, 1'b1) & ~32'h1, ALL);
        $display("test selected channel masking done");
        test_done();
    end
endmodule

`default_nettype wire
